//--- core/eii_channel.sv
// One external interrupt channel: per machine cycle sample, level or falling-edge detect.
// Assumes pin is already synchronised and samp_en is a one-cycle machine-cycle pulse.
`timescale 1ns/100ps
module eii_channel (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // Sampling
  input  wire logic samp_en,
  input  wire logic pin_sync,
  // Control
  input  wire logic trig_edge,
  input  wire logic vector_ack,
  input  wire logic sw_clear,
  // Result
  output logic      req_flag,
  output logic      edge_event
);
  import eii_pkg::*;

  logic prev_sample;       // Last machine-cycle sample
  logic next_prev_sample;
  logic next_req_flag;
  logic next_edge_event;

  // Detect per machine cycle; set wins over clear
  always_comb begin
    next_prev_sample = prev_sample;
    next_req_flag    = req_flag;
    next_edge_event  = 1'b0;
    if (trig_edge) begin
      // Edge mode: vector or software clears
      if (vector_ack || sw_clear) begin
        next_req_flag = 1'b0;
      end
      if (samp_en) begin
        next_prev_sample = pin_sync;
        if (prev_sample && !pin_sync) begin
          next_req_flag   = 1'b1;
          next_edge_event = 1'b1;
        end
      end
    end else begin
      // Level mode: flag tracks pin at each sample
      if (samp_en) begin
        next_prev_sample = pin_sync;
        next_req_flag    = !pin_sync;
        next_edge_event  = !pin_sync && !req_flag;
      end
    end
  end

  // State registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      prev_sample <= EII_RST_PREV;
      req_flag    <= 1'b0;
      edge_event  <= 1'b0;
    end else begin
      prev_sample <= next_prev_sample;
      req_flag    <= next_req_flag;
      edge_event  <= next_edge_event;
    end
  end

  a_edge_sets_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (trig_edge && samp_en && prev_sample && !pin_sync) |=> req_flag)
    else $error("edge not flagged");
  a_level_tracks: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!trig_edge && samp_en) |=> (req_flag == !$past(pin_sync)))
    else $error("level flag not tracking");
  a_vector_clears: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (trig_edge && vector_ack && !samp_en) |=> !req_flag)
    else $error("vector did not clear");
  a_flag_held: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!samp_en && !vector_ack && !sw_clear && $stable(trig_edge)) |=> $stable(req_flag))
    else $error("flag moved between samples");
  a_edge_no_spurious: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (trig_edge && !req_flag && !(samp_en && prev_sample && !pin_sync)) |=> !req_flag)
    else $error("edge flag set without a fall");
  a_reset_prev: assert property (@(posedge clk_sys)
    !rst_n |=> (prev_sample && !req_flag))
    else $error("reset state wrong");

endmodule // eii_channel

//--- core/eii_pkg.sv
// Package for the external interrupt inputs block: register map, fields, reset values, timing.
// Assumes a 40 MHz system clock and a 32-bit APB register bus.
package eii_pkg;

  // Register byte offsets
  localparam logic [7:0] EII_OFF_CTRL     = 8'h00;  // Trigger selects, request flags
  localparam logic [7:0] EII_OFF_ENABLE   = 8'h04;  // Per-input wake enables
  localparam logic [7:0] EII_OFF_STATUS   = 8'h08;  // Sticky event status, read only
  localparam logic [7:0] EII_OFF_CLEAR    = 8'h0c;  // Write one to clear status
  localparam logic [7:0] EII_OFF_IRQ_EN   = 8'h10;  // Status interrupt enable
  localparam logic [7:0] EII_OFF_PINS     = 8'h14;  // Synchronised pin levels

  // Control register fields
  localparam int EII_BIT_TRIG_ZERO = 0;  // trigger_select_zero
  localparam int EII_BIT_TRIG_ONE  = 1;  // trigger_select_one
  localparam int EII_BIT_REQ_ZERO  = 2;  // request_flag_zero
  localparam int EII_BIT_REQ_ONE   = 3;  // request_flag_one

  // Reset values
  localparam logic [1:0] EII_RST_TRIG = 2'h0;
  localparam logic [1:0] EII_RST_FLAG = 2'h0;
  localparam logic       EII_RST_PREV = 1'h1;
  localparam logic [1:0] EII_RST_EN   = 2'h0;

  // Timing: one machine cycle is six CPU clocks
  localparam int EII_CLK_HZ         = 40_000_000;
  localparam int EII_CPU_PER_MACH   = 6;
  localparam logic [2:0] EII_MACH_LAST = 3'(EII_CPU_PER_MACH - 1);

endpackage

//--- core/eii_top.sv
// External interrupt inputs: two channels, APB registers, status interrupt and wake.
// Assumes pins are asynchronous, active low; CPU gives vector acknowledges on clk_sys.
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/100ps
module eii_top (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // External request pins, active low
  input  wire logic        ext_request_pin_n_zero,
  input  wire logic        ext_request_pin_n_one,
  // CPU dispatch and power control
  input  wire logic        vector_ack_zero,
  input  wire logic        vector_ack_one,
  input  wire logic        low_power_mode,
  output logic             request_flag_zero,
  output logic             request_flag_one,
  output logic             wake_req,
  output logic             irq
);
  import eii_pkg::*;

  // Reset to the idle high level, so no false edge follows reset
  // Pin synchronisers, two stages each
  logic [1:0] pin_meta;
  logic [1:0] pin_sync;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pin_meta <= 2'h3;
      pin_sync <= 2'h3;
    end else begin
      pin_meta <= {ext_request_pin_n_one, ext_request_pin_n_zero};
      pin_sync <= pin_meta;
    end
  end

  // First sample enable comes five clocks after reset
  // Machine-cycle divider gives the sample enable
  logic [2:0] mach_cnt;
  logic [2:0] next_mach_cnt;
  logic       samp_en;
  always_comb begin
    next_mach_cnt = (mach_cnt == EII_MACH_LAST) ? 3'h0 : mach_cnt + 3'h1;
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mach_cnt <= 3'h0;
    end else begin
      mach_cnt <= next_mach_cnt;
    end
  end
  // Sample on the last count of each machine cycle
  assign samp_en = (mach_cnt == EII_MACH_LAST);

  // Only the low bits of each word are used; the rest read zero
  // Software state: trigger selects, enables, status
  logic [1:0] trig_sel;       // trigger_select_one, trigger_select_zero
  logic [1:0] wake_en;        // Per-input enable for wake
  logic [1:0] irq_en;         // Status interrupt enable
  logic [1:0] status;         // Sticky detection events
  logic [1:0] sw_clr;         // Software clear of edge flags
  logic [1:0] req;            // Channel flags
  logic [1:0] evt;            // Channel events
  logic [1:0] next_trig_sel;
  logic [1:0] next_wake_en;
  logic [1:0] next_irq_en;
  logic [1:0] next_status;
  logic [1:0] next_sw_clr;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic        acc;
  logic        wr;

  // Access start: decode now, answer with pready one clock later
  assign acc = psel && penable && !pready;
  // Writes commit on the edge at which the master samples pready high
  assign wr  = psel && penable && pready && pwrite;

  // Register file next state; hardware set wins over clear
  always_comb begin
    next_trig_sel = trig_sel;
    next_wake_en  = wake_en;
    next_irq_en   = irq_en;
    next_status   = status;
    next_sw_clr   = 2'h0;
    next_prdata   = prdata;
    next_pready   = acc;
    next_pslverr  = 1'b0;
    // Write commit, on the edge that completes the transfer
    if (wr) begin
      case (paddr)
        EII_OFF_CTRL: begin
          next_trig_sel = {pwdata[EII_BIT_TRIG_ONE], pwdata[EII_BIT_TRIG_ZERO]};
          // Writing zero to a flag bit clears an edge flag
          next_sw_clr = ~{pwdata[EII_BIT_REQ_ONE], pwdata[EII_BIT_REQ_ZERO]};
        end
        EII_OFF_ENABLE: next_wake_en = pwdata[1:0];
        EII_OFF_CLEAR:  next_status  = status & ~pwdata[1:0];
        EII_OFF_IRQ_EN: next_irq_en  = pwdata[1:0];
        // Read-only and unmapped offsets drop the write
        default:        next_sw_clr  = 2'h0;
      endcase
    end
    // Access start: read data and error stand with pready next cycle
    if (acc) begin
      case (paddr)
        EII_OFF_CTRL:   next_prdata = {28'h0, req[1], req[0], trig_sel};
        EII_OFF_ENABLE: next_prdata = {30'h0, wake_en};
        EII_OFF_STATUS: next_prdata = {30'h0, status};
        EII_OFF_CLEAR:  next_prdata = 32'h0;  // Write-only, reads zero
        EII_OFF_IRQ_EN: next_prdata = {30'h0, irq_en};
        EII_OFF_PINS:   next_prdata = {30'h0, pin_sync};
        // Unmapped offset: refused, data zero
        default: begin
          next_prdata  = 32'h0;
          next_pslverr = 1'b1;
        end
      endcase
    end
    // Detection events set status last, so they win over a clear
    next_status = next_status | evt;
  end

  // Register file; status clears at the commit edge, flag clears one clock later via sw_clr
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      trig_sel <= EII_RST_TRIG;
      wake_en  <= EII_RST_EN;
      irq_en   <= EII_RST_EN;
      status   <= EII_RST_FLAG;
      sw_clr   <= 2'h0;
      prdata   <= 32'h0;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
    end else begin
      trig_sel <= next_trig_sel;
      wake_en  <= next_wake_en;
      irq_en   <= next_irq_en;
      status   <= next_status;
      sw_clr   <= next_sw_clr;
      prdata   <= next_prdata;
      pready   <= next_pready;
      pslverr  <= next_pslverr;
    end
  end

  // Channels share the sample enable, so both see the same cycle
  // Two identical channels
  eii_channel u_ch_zero (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .samp_en    (samp_en),
    .pin_sync   (pin_sync[0]),
    .trig_edge  (trig_sel[0]),
    .vector_ack (vector_ack_zero),
    .sw_clear   (sw_clr[0]),
    .req_flag   (req[0]),
    .edge_event (evt[0])
  );
  // Input one, same logic and timing
  eii_channel u_ch_one (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .samp_en    (samp_en),
    .pin_sync   (pin_sync[1]),
    .trig_edge  (trig_sel[1]),
    .vector_ack (vector_ack_one),
    .sw_clear   (sw_clr[1]),
    .req_flag   (req[1]),
    .edge_event (evt[1])
  );

  // Registering costs one clock but gives the CPU glitch-free levels
  // Registered outputs to CPU, wake and interrupt
  logic next_wake;
  logic next_irq;
  always_comb begin
    next_wake = low_power_mode && |(req & wake_en);
    next_irq  = |(status & irq_en);
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      request_flag_zero <= 1'b0;
      request_flag_one  <= 1'b0;
      wake_req          <= 1'b0;
      irq               <= 1'b0;
    end else begin
      request_flag_zero <= req[0];
      request_flag_one  <= req[1];
      wake_req          <= next_wake;
      irq               <= next_irq;
    end
  end

  // Wake needs low power mode and an enabled, flagged input
  a_wake_follows: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (low_power_mode && (req[0] && wake_en[0])) |=> wake_req)
    else $error("wake not raised");
  a_wake_one: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (low_power_mode && (req[1] && wake_en[1])) |=> wake_req)
    else $error("wake not raised for input one");
  // No wake while running, and none without an enabled flag
  a_no_wake_awake: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !$past(low_power_mode) |-> !wake_req)
    else $error("wake while running");
  a_wake_masked: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !(|(req & wake_en)) |=> !wake_req)
    else $error("wake without an enabled flag");

  // Exactly one sample enable in every six clocks
  a_sample_period: assert property (@(posedge clk_sys) disable iff (!rst_n)
    samp_en |=> !samp_en [*5] ##1 samp_en)
    else $error("machine cycle not six clocks");
  // Both synchroniser stages are passed in turn
  a_sync_stages: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ##1 pin_sync == $past(pin_meta))
    else $error("synchroniser stage skipped");
  // Level mode: a low sample raises the request one clock later
  a_level_raises: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!trig_sel[0] && samp_en && !pin_sync[0]) |=> req[0])
    else $error("low level on input zero not flagged");
  a_level_one_raises: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!trig_sel[1] && samp_en && !pin_sync[1]) |=> req[1])
    else $error("low level on input one not flagged");
  // Flag outputs are the channel flags, one clock later
  a_flag_output: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ##1 request_flag_one == $past(req[1]))
    else $error("flag output mismatch");
  a_flag_zero_output: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ##1 request_flag_zero == $past(req[0]))
    else $error("flag zero output mismatch");

  // Reset leaves both selects cleared and both flags low
  a_reset_clears: assert property (@(posedge clk_sys)
    !rst_n |=> (trig_sel == EII_RST_TRIG) && !request_flag_zero && !request_flag_one)
    else $error("reset state not reached");

  // Interrupt output follows the enabled status bits
  a_irq_raised: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (|(status & irq_en)) |=> irq)
    else $error("irq not raised");
  a_irq_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !(|(status & irq_en)) |=> !irq)
    else $error("irq without enabled status");
  // Events set status; a bit stays until software clears it
  a_event_status: assert property (@(posedge clk_sys) disable iff (!rst_n)
    evt[0] |=> status[0])
    else $error("event zero not recorded");
  a_event_one_status: assert property (@(posedge clk_sys) disable iff (!rst_n)
    evt[1] |=> status[1])
    else $error("event one not recorded");
  a_status_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (status[0] && !(wr && paddr == EII_OFF_CLEAR)) |=> status[0])
    else $error("status zero lost");
  a_status_one_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (status[1] && !(wr && paddr == EII_OFF_CLEAR)) |=> status[1])
    else $error("status one lost");
  // A software clear of the edge flags lasts one clock
  a_clear_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (|sw_clr) |=> !(|sw_clr))
    else $error("flag clear longer than a clock");

  // Bus answer: pready one cycle after access start, one cycle wide
  a_ready_answer: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (psel && penable && !pready) |=> pready)
    else $error("access not answered");
  a_ready_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pready |=> !pready)
    else $error("pready longer than a clock");
  a_err_with_ready: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pslverr |-> pready)
    else $error("error without pready");

  // Main scenarios reached
  c_edge_seen: cover property (@(posedge clk_sys) disable iff (!rst_n)
    trig_sel[0] && evt[0]);
  c_level_seen: cover property (@(posedge clk_sys) disable iff (!rst_n)
    !trig_sel[1] && req[1]);
  c_wake_seen: cover property (@(posedge clk_sys) disable iff (!rst_n) wake_req);
  c_irq_seen: cover property (@(posedge clk_sys) disable iff (!rst_n) irq);
  c_refused: cover property (@(posedge clk_sys) disable iff (!rst_n)
    pready && pslverr);

endmodule // eii_top

//--- verif/eii_src.sv
// Model of the external request sources that drive both pins.
// Assumes the bench asks for pin levels on clk_sys; idle pins are pulled high.
`timescale 1ns/100ps
module eii_src (
  // Clock
  input  wire logic       clk_sys,
  // Requested levels, active low
  input  wire logic [1:0] want_n,
  // Pins into the block
  output logic            pin_n_zero,
  output logic            pin_n_one
);
  logic [1:0] pin_n = 2'h3;            // Pull-up level at start
  logic [3:0] held [2] = '{4'h6, 4'h6};  // Clocks spent at current level

  // A level changes only after six clocks, so no sample can miss it
  always @(posedge clk_sys) begin
    for (int i = 0; i < 2; i++) begin
      if (want_n[i] != pin_n[i] && held[i] >= 4'h6) begin
        pin_n[i] <= want_n[i];
        held[i]  <= 4'h1;
      end else if (held[i] < 4'hf) begin
        held[i] <= held[i] + 4'h1;
      end
    end
  end

  assign pin_n_zero = pin_n[0];
  assign pin_n_one  = pin_n[1];
endmodule // eii_src

//--- verif/eii_tb_top.sv
// Testbench for the external interrupt inputs block.
// Assumes a 40 MHz clk_sys, APB answers within a few clocks.
`timescale 1ns/100ps
module eii_tb_top;
  import eii_pkg::*;
  logic        clk_sys = 1'b0, rst_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, pz, po, f0, f1, wake, irq;
  logic        ack0 = 1'b0, ack1 = 1'b0, lpm = 1'b0;
  logic [1:0]  want_n = 2'h3;          // Both sources idle high
  int          fail_count = 0, n_compared = 0;
  // Reset-time reads: offset and value expected
  logic [7:0]  r_addr [5] = '{EII_OFF_CTRL, EII_OFF_ENABLE, EII_OFF_STATUS,
                              EII_OFF_IRQ_EN, EII_OFF_PINS};
  logic [31:0] r_exp [5] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h3};

  eii_src SRC (.clk_sys(clk_sys), .want_n(want_n), .pin_n_zero(pz), .pin_n_one(po));
  eii_top DUT (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .ext_request_pin_n_zero(pz),
    .ext_request_pin_n_one(po), .vector_ack_zero(ack0), .vector_ack_one(ack1),
    .low_power_mode(lpm), .request_flag_zero(f0), .request_flag_one(f1),
    .wake_req(wake), .irq(irq));

  // Clock, 25 ns period
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; holds the request until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    if (pready !== 1'b1) begin
      fail_count++;
      $display("[ERR] %0t no pready", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic results;
    if (fail_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Watchdog, far beyond the test length
  initial begin
    #(25 * 20000);
    fail_count++;
    $display("[ERR] %0t watchdog timeout", $time);
    results();
  end

  initial begin
    wt(3);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, r_addr[i], 32'h0);
      chk(rd, r_exp[i]);
    end
    // Level mode on input zero
    want_n[0] <= 1'b0;
    wt(20);
    chk({31'h0, f0}, 32'h1);
    chk({31'h0, f1}, 32'h0);
    // Level flag ignores the vector while the pin stays low
    ack0 <= 1'b1;
    wt(1);
    ack0 <= 1'b0;
    wt(8);
    chk({31'h0, f0}, 32'h1);
    want_n[0] <= 1'b1;
    wt(20);
    chk({31'h0, f0}, 32'h0);
    // Edge mode on input one
    apb(1'b1, EII_OFF_CTRL, 32'h2);
    want_n[1] <= 1'b0;
    wt(20);
    chk({31'h0, f1}, 32'h1);
    want_n[1] <= 1'b1;
    wt(20);
    chk({31'h0, f1}, 32'h1);
    ack1 <= 1'b1;
    wt(1);
    ack1 <= 1'b0;
    wt(3);
    chk({31'h0, f1}, 32'h0);
    // Edge mode on input zero, flag cleared by software
    apb(1'b1, EII_OFF_CTRL, 32'h3);
    want_n[0] <= 1'b0;
    wt(20);
    chk({31'h0, f0}, 32'h1);
    want_n[0] <= 1'b1;
    wt(20);
    apb(1'b1, EII_OFF_CTRL, 32'h3);
    wt(4);
    chk({31'h0, f0}, 32'h0);
    // Status interrupt: masked, enabled, cleared
    apb(1'b0, EII_OFF_STATUS, 32'h0);
    chk(rd, 32'h3);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, EII_OFF_IRQ_EN, 32'h3);
    wt(3);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, EII_OFF_CLEAR, 32'h3);
    wt(3);
    chk({31'h0, irq}, 32'h0);
    // Wake from low power
    apb(1'b1, EII_OFF_ENABLE, 32'h1);
    lpm <= 1'b1;
    want_n[0] <= 1'b0;
    wt(20);
    chk({31'h0, wake}, 32'h1);
    want_n[0] <= 1'b1;
    lpm <= 1'b0;
    // Unmapped offset is refused
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    // Mid-run reset returns selects, flags and outputs to idle
    rst_n <= 1'b0;
    wt(3);
    rst_n <= 1'b1;
    chk({28'h0, f1, f0, wake, irq}, 32'h0);
    apb(1'b0, EII_OFF_CTRL, 32'h0);
    chk(rd, 32'h0);
    results();
  end
endmodule // eii_tb_top
